/* File: mao_pkg.sv */
/*
 * Shared types and constants for the memory access ordering block.
 * Assumes one core clock domain; the memory side reports completion per slot id.
 */
`default_nettype none

package mao_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int MAO_ADDR_W = 32;
    localparam int MAO_HI_W = MAO_ADDR_W + 1;
    localparam int MAO_LEN_W = 3;
    localparam int MAO_DEPTH = 4;
    localparam int MAO_ID_W = 2;

    // ------------------------------------------------------------
    // Memory types and operation kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MT_UNCACHEABLE, MT_CACHE_DISABLED, MT_WRITE_COMBINING, MT_WRITE_COMBINING_PROBED,
        MT_WRITE_PROTECT, MT_WRITETHROUGH, MT_WRITEBACK
    } mao_mtype_e;

    typedef enum logic [3:0] {
        OP_LOAD, OP_STORE, OP_STORE_NON_TEMPORAL, OP_IO_LOAD, OP_IO_STORE,
        OP_LOCKED, OP_SERIALIZE, OP_LOAD_FENCE, OP_STORE_FENCE, OP_FULL_FENCE
    } mao_kind_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        mao_kind_e kind;
        mao_mtype_e mtype;
        logic [MAO_ADDR_W-1:0] addr;
        logic [MAO_LEN_W-1:0] len;      // Byte count minus one
        logic hit;                      // Line present in data or level-two cache
        logic dirty;                    // Present line is modified
    } mao_req_s;

    typedef struct packed {
        logic load;
        logic store;
        logic unc;                      // Uncacheable or cache-disabled
        logic comb;                     // Write-combining class or non-temporal store
        logic hard;                     // I/O or locked
        logic ser;
        logic lf;
        logic sf;
        logic mf;
    } mao_cls_s;

    typedef struct packed {
        logic valid;
        logic store;
        logic unc;
        logic comb;
        logic hard;
        logic lf;                       // A load or full fence follows this entry
        logic sf;                       // A store or full fence follows this entry
        logic mf;                       // A full fence follows this entry
        logic [MAO_ADDR_W-1:0] lo;
        logic [MAO_HI_W-1:0] hi;
    } mao_ent_s;

    typedef struct packed {
        logic valid;
        logic [MAO_ID_W-1:0] id;
        mao_kind_e kind;
        mao_mtype_e mtype;
        logic [MAO_ADDR_W-1:0] addr;
        logic [MAO_LEN_W-1:0] len;
        logic to_wcb;                   // Goes to write-combining buffers
        logic to_sb;                    // Goes to ordinary store buffers
        logic direct;                   // Goes straight to memory or I/O
        logic inval;                    // Invalidate the matching cache line
        logic wback_first;              // Write the modified line back first
        logic mem_update;               // Store must update memory
    } mao_iss_s;

    typedef struct packed {
        mao_ent_s [MAO_DEPTH-1:0] ent;
        logic ack;
        logic event_pend;
        mao_iss_s iss;
        logic sb_drain;
        logic wcb_flush;
        logic fetch_hold;
        logic fetch_go;
        logic fetch_from_cache;
        logic fetch_no_alloc;
        logic busy;
    } mao_state_s;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam mao_state_s MAO_STATE_RST = '0;

endpackage : mao_pkg

`default_nettype wire

/* File: mao_ordering.sv */
/*
 * Memory access ordering: decides when each load, store, I/O, locked or serializing
 * operation may issue past older outstanding ones, handles fences and fetch holds.
 * Assumes the requester holds a request until acknowledged and the memory side
 * reports each performed operation once by its slot id.
 */
`timescale 1ns/1ns
`default_nettype none

module mao_ordering
    import mao_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Pipeline requests
    input wire logic i_req_valid,
    input wire mao_req_s i_req,
    output logic o_req_ack,
    // Issue toward caches and buffers
    output mao_iss_s o_iss,
    // Completion from memory side
    input wire logic i_done_valid,
    input wire logic [MAO_ID_W-1:0] i_done_id,
    // Buffer status and flush requests
    input wire logic i_sb_empty,
    input wire logic i_wcb_empty,
    output logic o_sb_drain,
    output logic o_wcb_flush,
    // Interrupts and exceptions
    input wire logic i_event,
    // Instruction fetch path
    input wire logic i_fetch_valid,
    input wire logic i_fetch_cache_disabled,
    input wire logic i_ic_hit,
    output logic o_fetch_hold,
    output logic o_fetch_go,
    output logic o_fetch_from_cache,
    output logic o_fetch_no_alloc,
    // Status
    output logic o_busy
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Sort a request into ordering classes
    function automatic mao_cls_s classify(input mao_kind_e kind, input mao_mtype_e mt);
        mao_cls_s c;
        logic m_unc;
        logic m_comb;
        c = '0;
        m_unc = (mt == MT_UNCACHEABLE) || (mt == MT_CACHE_DISABLED);
        m_comb = (mt == MT_WRITE_COMBINING) || (mt == MT_WRITE_COMBINING_PROBED);
        unique case (kind)
            OP_LOAD: begin
                c.load = 1'b1;
                c.unc = m_unc;
                c.comb = m_comb;
            end
            OP_STORE: begin
                c.store = 1'b1;
                c.unc = m_unc;
                c.comb = m_comb;
            end
            OP_STORE_NON_TEMPORAL: begin
                c.store = 1'b1;
                c.comb = 1'b1;
            end
            OP_IO_LOAD: begin
                c.load = 1'b1;
                c.hard = 1'b1;
            end
            OP_IO_STORE, OP_LOCKED: begin
                c.store = 1'b1;
                c.hard = 1'b1;
            end
            OP_SERIALIZE: c.ser = 1'b1;
            OP_LOAD_FENCE: c.lf = 1'b1;
            OP_STORE_FENCE: c.sf = 1'b1;
            OP_FULL_FENCE: c.mf = 1'b1;
            default: c = '0;
        endcase
        return c;
    endfunction : classify

    // Byte range overlap test
    // address range compare
    function automatic logic overlap(input logic [MAO_ADDR_W-1:0] lo_a, input logic [MAO_HI_W-1:0] hi_a,
                                     input logic [MAO_ADDR_W-1:0] lo_b, input logic [MAO_HI_W-1:0] hi_b);
        return ({1'b0, lo_a} <= hi_b) && ({1'b0, lo_b} <= hi_a);
    endfunction : overlap

    // May a newer operation issue while an older entry is outstanding
    function automatic logic may_pass(input mao_ent_s o, input mao_cls_s n,
                                      input logic [MAO_ADDR_W-1:0] lo, input logic [MAO_HI_W-1:0] hi);
        logic conf;
        logic res;
        conf = overlap(o.lo, o.hi, lo, hi);
        res = 1'b0;
        if (!o.valid) begin
            res = 1'b1;
        end else if (o.hard) begin
            res = 1'b0;
        end else if (n.unc || o.unc) begin
            res = 1'b0;
        end else if (n.store && !o.store) begin
            res = 1'b0;
        end else if (n.load && !o.store) begin
            res = n.comb && !o.lf;
        end else if (n.load) begin
            res = !conf && !o.mf;
        end else if (!n.comb && !o.comb) begin
            res = 1'b0;
        end else if (!n.comb) begin
            res = !o.sf && !conf;
        end else if (!o.comb) begin
            res = !o.sf;
        end else begin
            res = !o.sf && !conf;
        end
        return res;
    endfunction : may_pass

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mao_state_s st_reg;
    mao_state_s st_next;

    // Next-state logic
    always_comb begin
        mao_cls_s cls;
        logic [MAO_ADDR_W-1:0] lo;
        logic [MAO_HI_W-1:0] hi;
        logic pass_all;
        logic any_valid;
        logic comb_fenced;
        logic quiet;
        logic free_ok;
        logic [MAO_ID_W-1:0] free_id;
        logic take;
        logic go;
        logic mem_op;
        cls = classify(i_req.kind, i_req.mtype);
        lo = i_req.addr;
        hi = {1'b0, i_req.addr} + MAO_HI_W'(i_req.len);
        pass_all = 1'b1;
        any_valid = 1'b0;
        comb_fenced = 1'b0;
        free_ok = 1'b0;
        free_id = '0;
        go = 1'b0;
        quiet = 1'b0;
        take = 1'b0;
        mem_op = 1'b0;
        st_next = st_reg;
        st_next.ack = 1'b0;
        st_next.iss.valid = 1'b0;

        // Scan outstanding entries, find first free slot
        for (int i = 0; i < MAO_DEPTH; i++) begin
            pass_all = pass_all & may_pass(st_reg.ent[i], cls, lo, hi);
            any_valid = any_valid | st_reg.ent[i].valid;
            comb_fenced = comb_fenced | (st_reg.ent[i].valid & st_reg.ent[i].comb & st_reg.ent[i].sf);
            if (!st_reg.ent[i].valid && !free_ok) begin
                free_ok = 1'b1;
                free_id = MAO_ID_W'(i);
            end
        end

        // Retire performed operations
        if (i_done_valid) begin
            st_next.ent[i_done_id].valid = 1'b0;
        end

        // quiet means all done and buffers empty
        quiet = !any_valid && i_sb_empty && i_wcb_empty;
        take = i_req_valid && !st_reg.ack;
        mem_op = cls.load || cls.store;

        // Decide whether the presented request may go now
        if (cls.lf || cls.sf || cls.mf) begin
            go = 1'b1;
        end else if (cls.ser || cls.hard) begin
            go = quiet && (cls.ser || free_ok);
        end else if (cls.unc) begin
            go = pass_all && free_ok && i_sb_empty && i_wcb_empty;
        end else if (mem_op) begin
            go = pass_all && free_ok;
        end

        if (take && go) begin
            st_next.ack = 1'b1;
            if (cls.lf || cls.sf || cls.mf) begin
                for (int i = 0; i < MAO_DEPTH; i++) begin
                    if (st_reg.ent[i].valid) begin
                        st_next.ent[i].lf = st_reg.ent[i].lf | cls.lf | cls.mf;
                        st_next.ent[i].sf = st_reg.ent[i].sf | cls.sf | cls.mf;
                        st_next.ent[i].mf = st_reg.ent[i].mf | cls.mf;
                    end
                end
            end
            if (mem_op) begin
                st_next.ent[free_id].valid = 1'b1;
                st_next.ent[free_id].store = cls.store;
                st_next.ent[free_id].unc = cls.unc;
                st_next.ent[free_id].comb = cls.comb;
                st_next.ent[free_id].hard = cls.hard;
                st_next.ent[free_id].lf = 1'b0;
                st_next.ent[free_id].sf = 1'b0;
                st_next.ent[free_id].mf = 1'b0;
                st_next.ent[free_id].lo = lo;
                st_next.ent[free_id].hi = hi;
                st_next.iss.valid = 1'b1;
                st_next.iss.id = free_id;
                st_next.iss.kind = i_req.kind;
                st_next.iss.mtype = i_req.mtype;
                st_next.iss.addr = i_req.addr;
                st_next.iss.len = i_req.len;
                st_next.iss.to_wcb = cls.store && cls.comb && !cls.hard;
                st_next.iss.to_sb = cls.store && !cls.comb && !cls.unc && !cls.hard;
                st_next.iss.direct = !(cls.store && !cls.unc && !cls.hard);
                st_next.iss.inval = i_req.hit && ((i_req.mtype == MT_CACHE_DISABLED) ||
                                    (cls.store && i_req.mtype == MT_WRITE_PROTECT));
                st_next.iss.wback_first = i_req.hit && i_req.dirty && (i_req.mtype == MT_CACHE_DISABLED);
                st_next.iss.mem_update = cls.store && (cls.hard || (i_req.mtype != MT_WRITEBACK) ||
                                         (i_req.kind == OP_STORE_NON_TEMPORAL));
            end
        end

        st_next.event_pend = (st_reg.event_pend && !quiet) || i_event;

        // Flush requests while something waits on buffers
        st_next.sb_drain = st_next.event_pend || (i_req_valid && (cls.unc || cls.hard || cls.ser));
        st_next.wcb_flush = st_next.sb_drain || comb_fenced || (take && (cls.sf || cls.mf));

        st_next.fetch_hold = st_next.event_pend || (i_req_valid && cls.ser && !(take && go));
        st_next.fetch_go = i_fetch_valid && !st_next.fetch_hold;
        st_next.fetch_from_cache = i_fetch_valid && i_ic_hit;
        st_next.fetch_no_alloc = i_fetch_valid && i_fetch_cache_disabled && !i_ic_hit;

        // Any operation still outstanding
        st_next.busy = 1'b0;
        for (int i = 0; i < MAO_DEPTH; i++) begin
            st_next.busy = st_next.busy | st_next.ent[i].valid;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_reg <= MAO_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_req_ack = st_reg.ack;
    assign o_iss = st_reg.iss;
    assign o_sb_drain = st_reg.sb_drain;
    assign o_wcb_flush = st_reg.wcb_flush;
    assign o_fetch_hold = st_reg.fetch_hold;
    assign o_fetch_go = st_reg.fetch_go;
    assign o_fetch_from_cache = st_reg.fetch_from_cache;
    assign o_fetch_no_alloc = st_reg.fetch_no_alloc;
    assign o_busy = st_reg.busy;

endmodule : mao_ordering

`default_nettype wire

/* File: mao_chk.sv */
/*
 * Port-level assertions for the ordering block, bound to mao_ordering.
 * Assumes one core clock and an active-low synchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none

module mao_chk
    import mao_pkg::*;
(
    // Clock, reset and inputs
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_req_valid,
    input wire mao_req_s i_req,
    input wire logic i_sb_empty,
    input wire logic i_wcb_empty,
    input wire logic i_event,
    input wire logic i_fetch_valid,
    input wire logic i_ic_hit,
    // Design outputs
    input wire logic o_req_ack,
    input wire mao_iss_s o_iss,
    input wire logic o_sb_drain,
    input wire logic o_wcb_flush,
    input wire logic o_fetch_hold,
    input wire logic o_fetch_go,
    input wire logic o_fetch_from_cache
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    chk_unc_buf_empty: assert property (o_iss.valid && o_iss.mtype == MT_UNCACHEABLE
        && o_iss.kind != OP_STORE_NON_TEMPORAL |-> $past(i_sb_empty && i_wcb_empty))
        else $error("uncacheable issued early");
    chk_unc_drain_req: assert property (i_req_valid && i_req.kind == OP_LOAD
        && i_req.mtype == MT_UNCACHEABLE && !o_req_ack |=> o_sb_drain) else $error("no drain for uncacheable");
    chk_hard_buf_empty: assert property (o_iss.valid && o_iss.kind inside {OP_IO_LOAD, OP_IO_STORE, OP_LOCKED}
        |-> $past(i_sb_empty && i_wcb_empty)) else $error("io issued early");
    chk_event_hold: assert property (i_event |=> o_fetch_hold && o_sb_drain && o_wcb_flush)
        else $error("event not held");
    chk_hold_no_go: assert property (o_fetch_hold |-> !o_fetch_go) else $error("fetch during hold");
    chk_fetch_cache: assert property (i_fetch_valid && i_ic_hit && !o_fetch_hold && !i_event
        && !(i_req_valid && i_req.kind == OP_SERIALIZE) |=> o_fetch_from_cache && o_fetch_go)
        else $error("hit not from cache");
    chk_wp_inval: assert property (o_iss.valid && o_iss.kind == OP_STORE && o_iss.mtype == MT_WRITE_PROTECT
        |-> o_iss.inval == $past(i_req.hit) && o_iss.mem_update) else $error("wp hit wrong");
    chk_disabled_wback: assert property (o_iss.valid && o_iss.kind == OP_LOAD && o_iss.mtype == MT_CACHE_DISABLED
        |-> o_iss.wback_first == $past(i_req.hit && i_req.dirty)) else $error("disabled hit writeback wrong");
    chk_comb_separate: assert property (o_iss.valid && o_iss.kind == OP_STORE_NON_TEMPORAL
        |-> o_iss.to_wcb && !o_iss.to_sb) else $error("non-temporal store not in combining buffer");
    chk_mem_update: assert property (o_iss.valid && o_iss.kind == OP_STORE
        && o_iss.mtype inside {MT_UNCACHEABLE, MT_WRITE_COMBINING} |-> o_iss.mem_update) else $error("no memory update");

    // Main scenarios
    cov_wcb_store: cover property (o_iss.valid && o_iss.to_wcb);
    cov_hold: cover property (o_fetch_hold);
    cov_inval: cover property (o_iss.valid && o_iss.inval);
endmodule : mao_chk

bind mao_ordering mao_chk mao_chk_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_sb_empty(i_sb_empty), .i_wcb_empty(i_wcb_empty), .i_event(i_event),
    .i_fetch_valid(i_fetch_valid), .i_ic_hit(i_ic_hit), .o_req_ack(o_req_ack), .o_iss(o_iss),
    .o_sb_drain(o_sb_drain), .o_wcb_flush(o_wcb_flush), .o_fetch_hold(o_fetch_hold),
    .o_fetch_go(o_fetch_go), .o_fetch_from_cache(o_fetch_from_cache));

`default_nettype wire

/* File: mao_mem_model.sv */
/*
 * Memory side model: takes issued operations, completes each after a few cycles
 * unless stalled, and reports store and write-combining buffer occupancy.
 */
`timescale 1ns/1ns
`default_nettype none

module mao_mem_model
    import mao_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Issue and stall control
    input wire mao_iss_s i_iss,
    input wire logic i_stall,
    // Completion and buffer state
    output logic o_done_valid,
    output logic [MAO_ID_W-1:0] o_done_id,
    output logic o_sb_empty,
    output logic o_wcb_empty
);
    logic [3:0] pend = '0;
    logic [3:0] sbf = '0;
    logic [3:0] wcf = '0;
    logic [3:0] age [4];
    logic fired;

    // Separate occupancy for each buffer kind
    assign o_sb_empty = (sbf == 4'h0);
    assign o_wcb_empty = (wcf == 4'h0);

    // One completion a cycle; idle id lines toggle
    always @(posedge i_clk) begin
        o_done_valid <= 1'b0;
        o_done_id <= ~o_done_id;
        fired = 1'b0;
        if (!i_rstn) begin
            pend <= '0;
            sbf <= '0;
            wcf <= '0;
        end else begin
            for (int s = 0; s < 4; s++) begin
                age[s] <= age[s] + 4'h1;
                if (pend[s] && age[s] > 4'h2 && !i_stall && !fired) begin
                    fired = 1'b1;
                    pend[s] <= 1'b0;
                    sbf[s] <= 1'b0;
                    wcf[s] <= 1'b0;
                    o_done_valid <= 1'b1;
                    o_done_id <= s[1:0];
                end
            end
            if (i_iss.valid) begin
                pend[i_iss.id] <= 1'b1;
                sbf[i_iss.id] <= i_iss.to_sb;
                wcf[i_iss.id] <= i_iss.to_wcb;
                age[i_iss.id] <= 4'h0;
            end
        end
    end
endmodule : mao_mem_model

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the ordering block with the memory model on its far side.
 * Assumes a 50 MHz clock and inputs changed on the rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
    import mao_pkg::*;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_req_valid = 1'b0;
    mao_req_s i_req = '0;
    logic i_event = 1'b0;
    logic i_fetch_valid = 1'b0;
    logic i_fetch_cache_disabled = 1'b0;
    logic i_ic_hit = 1'b0;
    logic stall = 1'b0;
    logic ack, sb_drain, wcb_flush, hold, go, from_cache, no_alloc, busy;
    logic done_valid, sb_empty, wcb_empty;
    logic [MAO_ID_W-1:0] done_id;
    mao_iss_s iss_w, iss;
    int error_cnt = 0;
    int checks_done = 0;

    always #10 i_clk = ~i_clk;

    mao_ordering mao_ordering_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ack(ack), .o_iss(iss_w), .i_done_valid(done_valid), .i_done_id(done_id), .i_sb_empty(sb_empty),
        .i_wcb_empty(wcb_empty), .o_sb_drain(sb_drain), .o_wcb_flush(wcb_flush), .i_event(i_event),
        .i_fetch_valid(i_fetch_valid), .i_fetch_cache_disabled(i_fetch_cache_disabled), .i_ic_hit(i_ic_hit),
        .o_fetch_hold(hold), .o_fetch_go(go), .o_fetch_from_cache(from_cache), .o_fetch_no_alloc(no_alloc),
        .o_busy(busy));
    mao_mem_model mao_mem_model_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_iss(iss_w), .i_stall(stall),
        .o_done_valid(done_valid), .o_done_id(done_id), .o_sb_empty(sb_empty), .o_wcb_empty(wcb_empty));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic set_stall(input logic v);
        @(posedge i_clk);
        stall <= v;
    endtask : set_stall

    // Present a request; expect it taken (within 60) or still refused after 8
    task automatic rq(input mao_kind_e k, input mao_mtype_e m, input logic [31:0] a, input logic e,
                      input logic h = 1'b0, input logic d = 1'b0);
        logic ok;
        ok = 1'b0;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req <= '{k, m, a, 3'h3, h, d};
        for (int n = 0; n < (e ? 60 : 8) && !ok; n++) begin
            @(posedge i_clk);
            #1;
            ok = (ack === 1'b1);
        end
        if (ok) begin
            iss = iss_w;
            @(posedge i_clk);
            i_req_valid <= 1'b0;
        end
        chk(ok, e);
    endtask : rq

    task automatic idle();
        for (int n = 0; n < 80 && busy !== 1'b0; n++) @(posedge i_clk);
        #1;
        chk(busy, 1'b0);
    endtask : idle

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_order();
        set_stall(1'b1);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0100, 1'b1);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0200, 1'b1);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0300, 1'b0);
        set_stall(1'b0);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0300, 1'b1);
        idle();
        set_stall(1'b1);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0100, 1'b1);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0102, 1'b0);
        set_stall(1'b0);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0102, 1'b1);
        idle();
        $display("t_order done");
    endtask : t_order

    // Fences placed by software
    task automatic t_fence();
        set_stall(1'b1);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0100, 1'b1);
        rq(OP_FULL_FENCE, MT_WRITEBACK, 32'h0000_0000, 1'b1);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0200, 1'b0);
        set_stall(1'b0);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0200, 1'b1);
        idle();
        set_stall(1'b1);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0100, 1'b1);
        rq(OP_LOAD, MT_WRITE_COMBINING, 32'h0000_0200, 1'b1);
        rq(OP_LOAD_FENCE, MT_WRITEBACK, 32'h0000_0000, 1'b1);
        rq(OP_LOAD, MT_WRITE_COMBINING, 32'h0000_0300, 1'b0);
        set_stall(1'b0);
        rq(OP_LOAD, MT_WRITE_COMBINING, 32'h0000_0300, 1'b1);
        idle();
        set_stall(1'b1);
        rq(OP_STORE_NON_TEMPORAL, MT_WRITEBACK, 32'h0000_0800, 1'b1);
        rq(OP_STORE_FENCE, MT_WRITEBACK, 32'h0000_0000, 1'b1);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0900, 1'b0);
        chk(wcb_flush, 1'b1);
        set_stall(1'b0);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0900, 1'b1);
        idle();
        set_stall(1'b1);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0a00, 1'b1);
        rq(OP_SERIALIZE, MT_WRITEBACK, 32'h0000_0000, 1'b0);
        chk(hold, 1'b1);
        set_stall(1'b0);
        rq(OP_SERIALIZE, MT_WRITEBACK, 32'h0000_0000, 1'b1);
        idle();
        $display("t_fence done");
    endtask : t_fence

    task automatic t_strict();
        set_stall(1'b1);
        rq(OP_STORE, MT_WRITEBACK, 32'h0000_0100, 1'b1);
        rq(OP_LOAD, MT_UNCACHEABLE, 32'h0000_0200, 1'b0);
        chk(sb_drain, 1'b1);
        set_stall(1'b0);
        rq(OP_LOAD, MT_UNCACHEABLE, 32'h0000_0200, 1'b1);
        set_stall(1'b1);
        rq(OP_IO_LOAD, MT_UNCACHEABLE, 32'h0000_0040, 1'b0);
        set_stall(1'b0);
        rq(OP_IO_LOAD, MT_UNCACHEABLE, 32'h0000_0040, 1'b1);
        set_stall(1'b1);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0400, 1'b0);
        set_stall(1'b0);
        rq(OP_LOAD, MT_WRITEBACK, 32'h0000_0400, 1'b1);
        idle();
        $display("t_strict done");
    endtask : t_strict

    task automatic t_wc();
        set_stall(1'b1);
        rq(OP_STORE_NON_TEMPORAL, MT_WRITEBACK, 32'h0000_0300, 1'b1);
        chk({iss.to_wcb, iss.to_sb, iss.direct}, 3'b100);
        rq(OP_STORE_NON_TEMPORAL, MT_WRITEBACK, 32'h0000_0301, 1'b0);
        set_stall(1'b0);
        rq(OP_STORE_NON_TEMPORAL, MT_WRITEBACK, 32'h0000_0301, 1'b1);
        rq(OP_STORE, MT_WRITE_PROTECT, 32'h0000_0500, 1'b1, 1'b1);
        chk({iss.inval, iss.mem_update, iss.direct}, 3'b110);
        rq(OP_LOAD, MT_CACHE_DISABLED, 32'h0000_0600, 1'b1, 1'b1, 1'b1);
        chk({iss.inval, iss.wback_first, iss.direct}, 3'b111);
        rq(OP_STORE, MT_WRITE_COMBINING, 32'h0000_0700, 1'b1);
        chk(iss.mem_update, 1'b1);
        idle();
        $display("t_wc done");
    endtask : t_wc

    task automatic t_fetch();
        @(posedge i_clk);
        i_fetch_valid <= 1'b1;
        i_event <= 1'b1;
        @(posedge i_clk);
        i_event <= 1'b0;
        #1;
        chk({hold, go}, 2'b10);
        @(posedge i_clk);
        #1;
        chk({hold, go}, 2'b01);
        for (int n = 0; n < 20 && hold !== 1'b0; n++) @(posedge i_clk);
        @(posedge i_clk);
        i_fetch_cache_disabled <= 1'b1;
        i_ic_hit <= 1'b1;
        @(posedge i_clk);
        i_ic_hit <= 1'b0;
        #1;
        chk({go, from_cache}, 2'b11);
        @(posedge i_clk);
        i_fetch_valid <= 1'b0;
        #1;
        chk(no_alloc, 1'b1);
        $display("t_fetch done");
    endtask : t_fetch

    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        t_order();
        t_fence();
        t_strict();
        t_wc();
        t_fetch();
        final_report();
    end

    // Watchdog
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
endmodule : tb

`default_nettype wire
